/* logic/tcm_consts.svh */
// Register map, field positions, counter limits and codes of the timer capture block.
// Functional notes
// RULE1 - Timer mode field 01 selects capture operation; edge-select field picks active edges.
// RULE2 - Each active capture edge copies the counter value into compare A.
// RULE3 - Clear-select bit is ignored in capture operation; counter reset unaffected.
// RULE4 - No output waveform in capture operation; level and polarity bits do nothing.
// RULE5 - Compare P match resets the counter; P of zero gives maximum range.
// RULE6 - Software must not use capture while the selected counter clock is unavailable.
// RULE7 - Counter starts on run bit rising, free runs until it falls; P match interrupts.
// RULE8 - Edge-select 11 disables captures while the counter keeps running.
// RULE9 - Compare A flag sets half a tick after latch; latch within 1.5 ticks. The code sets the flag one bus clock after the latch.
// RULE10 - Capture source bit picks capture or clock pin; never both capture and clock.
// RULE11 - With P at zero the counter wraps from all ones, 65536 ticks.
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH

`define TCM_ADDR_W        8
`define TCM_OFS_CTRL      8'h00
`define TCM_OFS_CMP_P     8'h04
`define TCM_OFS_CMP_A     8'h08
`define TCM_OFS_COUNT     8'h0C
`define TCM_OFS_STATUS    8'h10
`define TCM_OFS_CLEAR     8'h14
`define TCM_OFS_ENABLE    8'h18

`define TCM_CTRL_MODE_LO  0
`define TCM_CTRL_EDGE_LO  2
`define TCM_CTRL_CLRSEL   4
`define TCM_CTRL_OLEVEL   5
`define TCM_CTRL_OPOL     6
`define TCM_CTRL_CAPSRC   7
`define TCM_CTRL_RUN      8
`define TCM_CTRL_CLKSRC   9
`define TCM_CTRL_W        10

`define TCM_MODE_CAPTURE  2'h1
`define TCM_EDGE_RISE     2'h0
`define TCM_EDGE_FALL     2'h1
`define TCM_EDGE_BOTH     2'h2
`define TCM_EDGE_NONE     2'h3

`define TCM_IRQ_A         0
`define TCM_IRQ_P         1
`define TCM_IRQ_W         2

`define TCM_CNT_W         16
`define TCM_CNT_MAX       16'hFFFF
`define TCM_CNT_ZERO      16'h0000
`define TCM_CNT_STEP      16'h0001

`define TCM_RESP_OKAY     2'h0
`define TCM_RESP_SLVERR   2'h2

`endif

/* logic/tcm_pkg.sv */
// Types shared by the timer capture block.
package tcm_pkg;
`include "tcm_consts.svh"

   typedef struct packed {
      logic [`TCM_ADDR_W-1:0] awaddr;
      logic                   awvalid;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   wvalid;
      logic                   bready;
      logic [`TCM_ADDR_W-1:0] araddr;
      logic                   arvalid;
      logic                   rready;
   } tcm_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } tcm_axil_rsp_t;

   typedef struct packed {
      logic       clock_source;
      logic       counter_run_bit;
      logic       capture_source_bit;
      logic       output_polarity_bit;
      logic       output_level_bit;
      logic       clear_select_bit;
      logic [1:0] edge_select_field;
      logic [1:0] timer_mode_field;
   } tcm_ctrl_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tcm_sync_state_t;

   typedef struct packed {
      logic [`TCM_ADDR_W-1:0] awaddr;
      logic                   aw_have;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   w_have;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      tcm_ctrl_t              ctrl;
      logic [`TCM_CNT_W-1:0]  cmp_p;
      logic [`TCM_CNT_W-1:0]  cmp_a;
      logic [`TCM_CNT_W-1:0]  count;
      logic                   run_prev;
      logic                   cap_pend;
      logic                   a_flag_pend;
      logic [`TCM_IRQ_W-1:0]  status;
      logic [`TCM_IRQ_W-1:0]  enable;
   } tcm_state_t;
endpackage

/* logic/tcm_edge_sync.sv */
// Three-flop pin synchroniser with rising and falling edge pulses.
module tcm_edge_sync
   import tcm_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   import tcm_pkg::*;

   tcm_sync_state_t st;
   tcm_sync_state_t next_st;

   // Only the second and third stages feed logic, keeping the first stage free to settle.
   always_comb begin
      next_st    = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.s2;
   assign rise  = st.s2 & ~st.s3;
   assign fall  = ~st.s2 & st.s3;
endmodule

/* logic/tcm_timer_capture.sv */
// Capture input mode of a 16-bit timer with an AXI4-Lite register slave.
module tcm_timer_capture
   import tcm_pkg::*;
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire tcm_pkg::tcm_axil_req_t axi_req,
   output tcm_pkg::tcm_axil_rsp_t      axi_rsp,
   input  wire logic           capture_pin,
   input  wire logic           timer_clock_pin,
   output logic                timer_out,
   output logic                irq
);
   import tcm_pkg::*;

   tcm_state_t st;
   tcm_state_t next_st;

   logic cap_rise;
   logic cap_fall;
   logic tck_rise;
   logic tck_fall;

   // Only the edge pulses drive logic here, so the synchronised levels stay unconnected.
   tcm_edge_sync u_cap_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (capture_pin),
      .level   (),
      .rise    (cap_rise),
      .fall    (cap_fall)
   );

   tcm_edge_sync u_tck_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (timer_clock_pin),
      .level   (),
      .rise    (tck_rise),
      .fall    (tck_fall)
   );

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_val[8*i +: 8];
         end
      end
      return res;
   endfunction

   logic                  tick;
   logic                  sel_rise;
   logic                  sel_fall;
   logic                  active_edge;
   logic                  capture_mode;
   logic                  p_match;
   logic                  run_start;
   logic [`TCM_IRQ_W-1:0] hw_set;
   logic                  do_write;
   logic                  do_read;
   logic [31:0]           ctrl_word;
   logic [31:0]           wr_val;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[`TCM_CTRL_W-1:0] = st.ctrl;
   end

   // The timer ticks on every bus clock or on rising edges of the timer clock pin.
   // With the pin as source and the pin idle, nothing counts and nothing is captured.
   assign tick = st.ctrl.clock_source ? tck_rise : 1'b1;  // see RULE6

   // The capture source picks the pin; software must not pair it with the pin clock.
   assign sel_rise = st.ctrl.capture_source_bit ? tck_rise : cap_rise;  // see RULE10
   assign sel_fall = st.ctrl.capture_source_bit ? tck_fall : cap_fall;  // see RULE10

   assign capture_mode = (st.ctrl.timer_mode_field == `TCM_MODE_CAPTURE);  // see RULE1

   always_comb begin
      case (st.ctrl.edge_select_field)  // see RULE1
         `TCM_EDGE_RISE: active_edge = sel_rise;
         `TCM_EDGE_FALL: active_edge = sel_fall;
         `TCM_EDGE_BOTH: active_edge = sel_rise | sel_fall;
         `TCM_EDGE_NONE: active_edge = 1'b0;  // see RULE8
         default:        active_edge = 1'b0;
      endcase
   end

   // Clear-select takes no part in the wrap decision.
   assign p_match = (st.cmp_p == `TCM_CNT_ZERO) ? (st.count == `TCM_CNT_MAX)  // see RULE11
                                                 : (st.count == st.cmp_p);   // see RULE5, RULE3
   assign run_start = st.ctrl.counter_run_bit & ~st.run_prev;  // see RULE7

   assign do_write = st.aw_have & st.w_have & ~st.bvalid;
   assign do_read  = axi_req.arvalid & ~st.rvalid;

   always_comb begin
      next_st  = st;
      hw_set   = '0;
      wr_val   = merge_bytes('0, st.wdata, st.wstrb);

      next_st.run_prev = st.ctrl.counter_run_bit;

      // Counter.
      if (run_start) begin
         next_st.count = `TCM_CNT_ZERO;  // see RULE7
      end else if (st.ctrl.counter_run_bit && tick) begin
         if (p_match) begin
            next_st.count     = `TCM_CNT_ZERO;  // see RULE5, RULE11
            hw_set[`TCM_IRQ_P] = 1'b1;          // see RULE7
         end else begin
            next_st.count = st.count + `TCM_CNT_STEP;
         end
      end

      // An edge is held until the next tick, which bounds the latch delay to one tick.
      if (capture_mode && active_edge && st.ctrl.counter_run_bit) begin
         next_st.cap_pend = 1'b1;  // see RULE2, RULE8
      end
      if (st.cap_pend && tick) begin
         next_st.cap_pend    = capture_mode && active_edge && st.ctrl.counter_run_bit;
         next_st.cmp_a       = st.count;  // see RULE2, RULE9
         next_st.a_flag_pend = 1'b1;
      end else begin
         next_st.a_flag_pend = 1'b0;
      end
      // The flag follows the latch by one bus clock, standing in for the half tick.
      if (st.a_flag_pend) begin
         hw_set[`TCM_IRQ_A] = 1'b1;  // see RULE9
      end

      // Write channel: address and data are taken independently.
      if (axi_req.awvalid && !st.aw_have && !st.bvalid) begin
         next_st.aw_have = 1'b1;
         next_st.awaddr  = axi_req.awaddr;
      end
      if (axi_req.wvalid && !st.w_have && !st.bvalid) begin
         next_st.w_have = 1'b1;
         next_st.wdata  = axi_req.wdata;
         next_st.wstrb  = axi_req.wstrb;
      end
      if (do_write) begin
         next_st.aw_have = 1'b0;
         next_st.w_have  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = `TCM_RESP_OKAY;
         // Each merged word is cut back to the width of the register it lands in.
         case (st.awaddr)
            `TCM_OFS_CTRL: begin
               next_st.ctrl = tcm_ctrl_t'(`TCM_CTRL_W'(merge_bytes(ctrl_word, st.wdata, st.wstrb)));
            end
            `TCM_OFS_CMP_P: begin
               next_st.cmp_p = `TCM_CNT_W'(merge_bytes({16'h0000, st.cmp_p}, st.wdata, st.wstrb));
            end
            `TCM_OFS_CMP_A: begin
               next_st.cmp_a = `TCM_CNT_W'(merge_bytes({16'h0000, st.cmp_a}, st.wdata, st.wstrb));
            end
            `TCM_OFS_CLEAR: begin
               next_st.status = st.status & ~wr_val[`TCM_IRQ_W-1:0];
            end
            `TCM_OFS_ENABLE: begin
               next_st.enable = `TCM_IRQ_W'(merge_bytes({30'h0, st.enable}, st.wdata, st.wstrb));
            end
            `TCM_OFS_COUNT, `TCM_OFS_STATUS: begin
               next_st.bresp = `TCM_RESP_OKAY;
            end
            default: begin
               next_st.bresp = `TCM_RESP_SLVERR;
            end
         endcase
      end
      if (st.bvalid && axi_req.bready) begin
         next_st.bvalid = 1'b0;
      end

      // Hardware set wins over a software clear in the same cycle.
      next_st.status = next_st.status | hw_set;

      // Read channel.
      if (do_read) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `TCM_RESP_OKAY;
         next_st.rdata  = '0;
         case (axi_req.araddr)
            `TCM_OFS_CTRL:   next_st.rdata = ctrl_word;
            `TCM_OFS_CMP_P:  next_st.rdata = {16'h0000, st.cmp_p};
            `TCM_OFS_CMP_A:  next_st.rdata = {16'h0000, st.cmp_a};
            `TCM_OFS_COUNT:  next_st.rdata = {16'h0000, st.count};
            `TCM_OFS_STATUS: next_st.rdata = {30'h0, st.status};
            `TCM_OFS_ENABLE: next_st.rdata = {30'h0, st.enable};
            `TCM_OFS_CLEAR:  next_st.rdata = 32'h0000_0000;
            default:         next_st.rresp = `TCM_RESP_SLVERR;
         endcase
      end else if (st.rvalid && axi_req.rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      axi_rsp         = '0;
      axi_rsp.awready = ~st.aw_have & ~st.bvalid;
      axi_rsp.wready  = ~st.w_have & ~st.bvalid;
      axi_rsp.bvalid  = st.bvalid;
      axi_rsp.bresp   = st.bresp;
      axi_rsp.arready = ~st.rvalid;
      axi_rsp.rvalid  = st.rvalid;
      axi_rsp.rresp   = st.rresp;
      axi_rsp.rdata   = st.rdata;
   end

   // Only capture mode is built here, so the waveform pin stays low whatever
   // the level and polarity bits hold; the pin levels themselves are not needed.
   assign timer_out = 1'b0;  // see RULE4
   assign irq       = |(st.status & st.enable);
endmodule

/* verif/tcm_capture_monitor.sv */
// Concurrent checks on the register bus and the waveform output of the timer capture block.
module tcm_capture_monitor
   import tcm_pkg::*;
(
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire tcm_pkg::tcm_axil_req_t axi_req,
   input wire tcm_pkg::tcm_axil_rsp_t axi_rsp,
   input wire logic                   timer_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd_taken; axi_req.arvalid && axi_rsp.arready; endsequence
   sequence s_wr_taken; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready; endsequence
   property p_no_wave; timer_out == 1'b0; endproperty
   a_no_wave: assert property (p_no_wave) else $error("timer output driven in capture mode");
   property p_rd_answer; s_rd_taken |-> ##[1:2] axi_rsp.rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_wr_answer; s_wr_taken |-> ##[1:2] axi_rsp.bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_rd_single; s_rd_taken |=> !axi_rsp.arready; endproperty
   a_rd_single: assert property (p_rd_single) else $error("second read accepted");
   property p_wr_single; s_wr_taken |=> !axi_rsp.awready && !axi_rsp.wready; endproperty
   a_wr_single: assert property (p_wr_single) else $error("second write accepted");
   property p_b_done; axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write answer repeated");
   property p_r_done; axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid; endproperty
   a_r_done: assert property (p_r_done) else $error("read answer repeated");
   property p_aw_busy; axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready; endproperty
   a_aw_busy: assert property (p_aw_busy) else $error("write taken while answer pending");
   property p_ar_busy; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while answer pending");
endmodule

bind tcm_timer_capture tcm_capture_monitor i_mon (
   .aclk      (aclk),
   .aresetn   (aresetn),
   .axi_req   (axi_req),
   .axi_rsp   (axi_rsp),
   .timer_out (timer_out)
);

/* verif/tcm_capture_source.sv */
// Behavioural signal source on the capture pin.
module tcm_capture_source (
   input  wire logic aclk,
   output logic      capture_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // This pin feeds captures except in the capture source test; the clock pin never serves as both.
   // The counter runs from the bus clock except in the clock source test, which clocks it from the clock pin.
   initial capture_pin = 1'b0;
   // Changes the pin just after an edge, then stays put for settle cycles.
   task automatic toggle(input int settle);
      capture_pin <= ~capture_pin;
      repeat (settle) @(posedge aclk);
   endtask
endmodule

/* verif/tcm_timer_capture_tb_top.sv */
// Self-checking bench for the timer capture block.
module tcm_timer_capture_tb_top
   import tcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          aclk, aresetn, timer_out, irq, cap_pin, hit;
   logic          clk_pin = 1'b0;
   bit            tck_hold, tck_val, tck_prev;
   tcm_axil_req_t req;
   tcm_axil_rsp_t rsp;
   logic [31:0]   d;
   logic [1:0]    r;
   int            bad_count, comparisons, cyc, s, t, k, e, ph, n, tck_edges;
   bit            exp_q[$] = '{1, 0, 0, 1, 1, 1};

   tcm_timer_capture i_dut (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .axi_req         (req),
      .axi_rsp         (rsp),
      .capture_pin     (cap_pin),
      .timer_clock_pin (clk_pin),
      .timer_out       (timer_out),
      .irq             (irq)
   );
   tcm_capture_source i_src (
      .aclk        (aclk),
      .capture_pin (cap_pin)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // The clock pin wanders at random unless held; with the bus clock selected it must change nothing.
   // Its rising edges are counted here to check the counter when the pin is the counter clock.
   always @(posedge aclk) begin
      cyc      <= cyc + 1;
      clk_pin  <= tck_hold ? tck_val : 1'($urandom);
      tck_prev <= clk_pin;
      if (clk_pin && !tck_prev)
         tck_edges <= tck_edges + 1;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      req.awaddr  <= a;
      req.wdata   <= v;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            r = rsp.bresp;
            t = cyc;
            return;
         end
      end
      bad_count++;
      wrap_up();
   endtask
   task automatic rd(input logic [7:0] a);
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            d = rsp.rdata;
            r = rsp.rresp;
            return;
         end
      end
      bad_count++;
      wrap_up();
   endtask
   task automatic wait_irq(input int lim, input bit must);
      hit = 1'b0;
      for (n = 0; n < lim && !hit; n++) begin
         @(posedge aclk);
         hit = (irq === 1'b1);
      end
      if (must && !hit) begin
         bad_count++;
         wrap_up();
      end
   endtask

   initial begin
      // Both answer channels stay ready, so no answer ever waits on the bench.
      req         = '0;
      req.wstrb   = 4'hF;
      req.bready  = 1'b1;
      req.rready  = 1'b1;
      aresetn     = 1'b0;
      bad_count   = 0;
      comparisons = 0;
      void'($urandom(32'hE00C));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) begin
         if (a != 20) begin
            rd(8'(a));
            chk("reset value", d, 32'h0);
            chk("read response", 32'(r), (a == 28) ? 32'h2 : 32'h0);
         end
      end
      wr(8'h0C, 32'h1234);
      rd(8'h0C);
      chk("count read only", d, 32'h0);
      wr(8'h20, 32'h1);
      chk("unmapped write", 32'(r), 32'h2);
      $display("test register map done");
      k = $urandom_range(40, 20);
      wr(8'h04, 32'(k));
      wr(8'h18, 32'h2);
      // Clear select, level and polarity set on purpose; edge select is none.
      wr(8'h00, 32'h17D);
      s = t;
      i_src.toggle(15);
      wait_irq(100, 1'b1);
      chk("period", 32'(cyc - s >= k && cyc - s <= k + 4), 32'h1);
      i_src.toggle(5);
      rd(8'h10);
      chk("status no capture", d, 32'h2);
      rd(8'h08);
      chk("compare a kept", d, 32'h0);
      wr(8'h18, 32'h0);
      chk("irq masked", 32'(irq), 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h3);
      rd(8'h10);
      chk("status cleared", d, 32'h0);
      $display("test period done");
      wr(8'h04, 32'h0);
      wr(8'h18, 32'h1);
      for (e = 0; e < 3; e++) begin
         wr(8'h00, 32'h1);
         wr(8'h00, 32'h101 | (e << 2));
         s = t;
         for (ph = 0; ph < 2; ph++) begin
            repeat (20) @(posedge aclk);
            k = cyc - s;
            i_src.toggle(0);
            wait_irq(12, 1'b0);
            chk("capture seen", 32'(hit), 32'(exp_q.pop_front()));
            if (hit) begin
               rd(8'h08);
               chk("captured count", 32'(d >= k && d <= k + 8), 32'h1);
               wr(8'h14, 32'h1);
            end
         end
      end
      $display("test capture edges done");
      // A full sixteen-bit lap is long, so only one is run.
      wr(8'h18, 32'h2);
      wait_irq(70000, 1'b1);
      chk("full range", 32'(cyc - s >= 65535 && cyc - s <= 65541), 32'h1);
      $display("test full range done");
      // The bench now holds the clock pin and uses it as the capture input.
      wr(8'h18, 32'h1);
      tck_val  <= 1'b0;
      tck_hold <= 1'b1;
      wr(8'h14, 32'h3);
      repeat (4) @(posedge aclk);
      wr(8'h00, 32'h181);
      rd(8'h10);
      chk("steady clock pin", d, 32'h0);
      tck_val <= 1'b1;
      wait_irq(12, 1'b0);
      chk("capture from clock pin", 32'(hit), 32'h1);
      $display("test capture source done");
      // With the clock pin held still as counter clock, nothing counts and nothing is captured.
      tck_val <= 1'b0;
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h3);
      wr(8'h00, 32'h301);
      i_src.toggle(0);
      wait_irq(12, 1'b0);
      chk("no capture without clock", 32'(hit), 32'h0);
      rd(8'h0C);
      chk("count without clock", d, 32'h0);
      tck_hold <= 1'b0;
      s = tck_edges;
      repeat (100) @(posedge aclk);
      e = tck_edges - s;
      rd(8'h0C);
      chk("count from clock pin", 32'(d + 4 >= e && d <= e + 4 && e > 0), 32'h1);
      $display("test clock source done");
      wrap_up();
   end
endmodule
